// ===== bench/flcu_checker_properties.sv
// concurrent checks on the fuse lock config unit ports
module flcu_checker #(
  parameter logic [7:0] SIG_BYTE0 = 8'hA5,
  parameter logic [7:0] CAL_3V = 8'h80,
  parameter logic [7:0] CAL_5V = 8'h80
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_prog_mode,
  input wire logic i_fuse_wr,
  input wire logic [1:0] i_fuse_wsel,
  input wire logic i_mem_lock_first,
  input wire logic [1:0] i_sig_addr,
  input wire logic i_sig_cal_sel,
  input wire logic i_chip_erase,
  input wire logic i_cpu_reset,
  input wire logic i_boot_lock_hi,
  input wire logic i_boot_lock_lo,
  input wire logic i_store_to_boot,
  input wire logic i_load_of_boot,
  input wire logic i_exec_in_boot,
  input wire logic i_vectors_in_app,
  input wire logic o_store_blocked,
  input wire logic o_load_blocked,
  input wire logic o_int_disable,
  input wire logic [7:0] o_sig_rdata,
  input wire logic o_fuse_wr_rejected,
  input wire logic o_data_erase,
  input wire logic [7:0] o_osc_calibration_reg,
  input wire logic o_keep_data_on_erase,
  input wire logic o_clock_div_eight,
  input wire logic o_clock_out_pin_en,
  input wire logic o_latched
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // decode has no register, so same-cycle equality
  chk_store_decode: assert property (
    o_store_blocked == (i_store_to_boot && !i_boot_lock_lo)) else $error("store block wrong");
  chk_load_decode: assert property (
    o_load_blocked == (i_load_of_boot && !i_exec_in_boot && !i_boot_lock_hi))
    else $error("load block wrong");
  chk_int_decode: assert property (
    o_int_disable == (!i_boot_lock_hi && i_vectors_in_app && i_exec_in_boot))
    else $error("int disable wrong");
  chk_wr_reject: assert property (
    i_fuse_wr && (!i_prog_mode || !i_mem_lock_first || i_fuse_wsel == 2'h3)
    |=> o_fuse_wr_rejected) else $error("bad write not rejected");
  chk_cal_load: assert property (
    i_cpu_reset |=> o_osc_calibration_reg == CAL_3V) else $error("cal not loaded");
  chk_sig_first: assert property (
    !i_sig_cal_sel && i_sig_addr == flcu_pkg::SIG_ADDR_0 |=> o_sig_rdata == SIG_BYTE0)
    else $error("signature byte wrong");
  chk_cal_high: assert property (
    i_sig_cal_sel && i_sig_addr == flcu_pkg::CAL_ADDR_5V |=> o_sig_rdata == CAL_5V)
    else $error("5V cal byte wrong");
  chk_erase_data: assert property (
    i_chip_erase |=> o_data_erase != $past(o_keep_data_on_erase))
    else $error("data erase wrong");
  // after the power-up latch, latched copies move only around a mode change
  chk_latch_hold: assert property (
    $stable(i_prog_mode) [*4] ##0 $past(o_latched)
    |-> $stable(o_clock_out_pin_en) && $stable(o_clock_div_eight))
    else $error("latched fuse moved");
  cover property (i_fuse_wr ##1 o_fuse_wr_rejected);
  cover property ($fell(i_prog_mode));
  cover property (i_chip_erase ##1 !o_data_erase);
endmodule : flcu_checker

bind flcu_fuse_lock_config_unit flcu_checker #(.SIG_BYTE0(SIG_BYTE0), .CAL_3V(CAL_3V),
  .CAL_5V(CAL_5V)) u_flcu_checker (.*);

// ===== bench/flcu_fuse_lock_config_unit_tb_top.sv
// self-checking bench for the fuse lock config unit
module flcu_fuse_lock_config_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SIG0 = 8'hA5; // arbitrary identity value
  localparam logic [7:0] SIG1 = 8'h5A; // arbitrary identity value
  localparam logic [7:0] SIG2 = 8'h3C; // arbitrary identity value
  logic i_ref_clk, i_srst, i_prog_mode, i_serial_path, i_fuse_wr, i_mem_lock_first;
  logic i_sig_cal_sel, i_chip_erase, i_cpu_reset, i_boot_lock_hi, i_boot_lock_lo;
  logic i_store_to_boot, i_load_of_boot, i_exec_in_boot, i_vectors_in_app;
  logic [1:0] i_fuse_wsel, i_fuse_rsel, i_sig_addr, o_boot_size, o_startup_time;
  logic [7:0] i_fuse_wdata, i_lock_byte, o_fuse_rdata, o_sig_rdata, o_osc_calibration_reg;
  logic o_store_blocked, o_load_blocked, o_int_disable, o_fuse_wr_rejected, o_data_erase;
  logic o_debug_enable, o_test_port_enable, o_serial_prog_enable, o_watchdog_forced_on;
  logic o_keep_data_on_erase, o_reset_vector_select, o_clock_div_eight, o_clock_keep_in_sleep;
  logic o_clock_out_pin_en, o_latched;
  logic [2:0] o_brownout_level;
  logic [3:0] o_clock_source;
  logic [7:0] flags, fields;
  int fails, compares;
  flcu_fuse_lock_config_unit #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
    .CAL_3V(8'h4B), .CAL_5V(8'hB4)) u_flcu_fuse_lock_config_unit (.*);
  flcu_programmer_model u_flcu_programmer_model (.i_ref_clk(i_ref_clk),
    .o_prog_mode(i_prog_mode), .o_serial_path(i_serial_path), .o_fuse_wr(i_fuse_wr),
    .o_fuse_wsel(i_fuse_wsel), .o_fuse_wdata(i_fuse_wdata),
    .o_mem_lock_first(i_mem_lock_first), .o_lock_byte(i_lock_byte));
  // packed views of the decode outputs, all latched except o_keep_data_on_erase (live cell)
  assign flags = {o_debug_enable, o_test_port_enable, o_serial_prog_enable,
    o_watchdog_forced_on, o_keep_data_on_erase, o_reset_vector_select,
    o_clock_div_eight, o_clock_out_pin_en};
  assign fields = {o_boot_size, o_startup_time, o_clock_source};
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp
  task rdf(input logic [1:0] sel, input logic [7:0] exp);
    @(negedge i_ref_clk) i_fuse_rsel = sel;
    @(negedge i_ref_clk) cmp(o_fuse_rdata, exp);
  endtask : rdf
  task rds(input logic cs, input logic [1:0] a, input logic [7:0] exp);
    @(negedge i_ref_clk) {i_sig_cal_sel, i_sig_addr} = {cs, a};
    @(negedge i_ref_clk) cmp(o_sig_rdata, exp);
  endtask : rds
  task erase(input logic [7:0] exp);
    @(negedge i_ref_clk) i_chip_erase = 1'b1;
    @(negedge i_ref_clk) i_chip_erase = 1'b0;
    cmp(o_data_erase, exp);
  endtask : erase
  task t_defaults;
    rdf(flcu_pkg::RSEL_LOW, 8'h62);
    rdf(flcu_pkg::RSEL_HIGH, 8'h99);
    rdf(flcu_pkg::RSEL_EXT, 8'hFD);
    cmp(flags, 8'h62);
    cmp(fields, 8'h22);
    cmp({o_brownout_level, o_clock_keep_in_sleep, o_latched}, 8'h15);
    erase(8'h01);
    @(negedge i_ref_clk) i_cpu_reset = 1'b1;
    @(negedge i_ref_clk) i_cpu_reset = 1'b0;
    cmp(o_osc_calibration_reg, 8'h4B);
    $display("test defaults done");
  endtask : t_defaults
  // every lock pair against every access pattern
  task t_lock_modes;
    for (int m = 0; m < 64; m++) begin
      @(negedge i_ref_clk) {i_boot_lock_hi, i_boot_lock_lo, i_store_to_boot,
        i_load_of_boot, i_exec_in_boot, i_vectors_in_app} = m[5:0];
      #1;
      cmp(o_store_blocked, m[3] & ~m[4]);
      cmp(o_load_blocked, m[2] & ~m[1] & ~m[5]);
      cmp(o_int_disable, ~m[5] & m[1] & m[0]);
    end
    $display("test lock modes done");
  endtask : t_lock_modes
  task t_program;
    u_flcu_programmer_model.enter(1'b0);
    u_flcu_programmer_model.write_fuse(flcu_pkg::WSEL_LOW, 8'hA1);
    u_flcu_programmer_model.write_fuse(flcu_pkg::WSEL_HIGH, 8'h57);
    u_flcu_programmer_model.write_fuse(2'h3, 8'h00);
    cmp(o_fuse_wr_rejected, 8'h01);
    rdf(flcu_pkg::RSEL_LOW, 8'hA1);
    cmp(flags, 8'h6A);
    u_flcu_programmer_model.leave();
    repeat (3) @(negedge i_ref_clk);
    cmp(flags, 8'hA9);
    cmp(fields, 8'hE1);
    cmp(o_clock_keep_in_sleep, 8'h01);
    erase(8'h00);
    rdf(flcu_pkg::RSEL_LOW, 8'hA1);
    u_flcu_programmer_model.enter(1'b1);
    u_flcu_programmer_model.write_fuse(flcu_pkg::WSEL_HIGH, 8'h77);
    rdf(flcu_pkg::RSEL_HIGH, 8'h57);
    u_flcu_programmer_model.write_fuse(flcu_pkg::WSEL_EXT, 8'h02);
    rdf(flcu_pkg::RSEL_EXT, 8'hFA);
    u_flcu_programmer_model.leave();
    $display("test program done");
  endtask : t_program
  task t_locked;
    u_flcu_programmer_model.lock_memory();
    u_flcu_programmer_model.enter(1'b0);
    u_flcu_programmer_model.write_fuse(flcu_pkg::WSEL_LOW, 8'h00);
    cmp(o_fuse_wr_rejected, 8'h01);
    cmp(o_brownout_level, 8'h02);
    rdf(flcu_pkg::RSEL_LOW, 8'hA1);
    rdf(flcu_pkg::RSEL_LOCK, 8'hFE);
    rds(1'b0, flcu_pkg::SIG_ADDR_0, SIG0);
    rds(1'b0, flcu_pkg::SIG_ADDR_1, SIG1);
    rds(1'b0, flcu_pkg::SIG_ADDR_2, SIG2);
    rds(1'b0, 2'h3, 8'hFF);
    rds(1'b1, flcu_pkg::CAL_ADDR_3V, 8'h4B);
    rds(1'b1, flcu_pkg::CAL_ADDR_5V, 8'hB4);
    rds(1'b1, 2'h0, 8'hFF);
    u_flcu_programmer_model.leave();
    $display("test locked done");
  endtask : t_locked
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, far beyond the run length
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
  initial begin
    {i_srst, i_fuse_rsel, i_sig_addr, i_sig_cal_sel, i_chip_erase, i_cpu_reset} = 8'h80;
    {i_boot_lock_hi, i_boot_lock_lo, i_store_to_boot} = 3'h6;
    {i_load_of_boot, i_exec_in_boot, i_vectors_in_app} = 3'h0;
    repeat (3) @(negedge i_ref_clk);
    i_srst = 1'b0;
    @(negedge i_ref_clk);
    t_defaults();
    t_lock_modes();
    t_program();
    t_locked();
    tally_and_finish();
  end
endmodule : flcu_fuse_lock_config_unit_tb_top

// ===== bench/flcu_programmer_model.sv
// external programmer driving fuse writes and memory locks
module flcu_programmer_model (
  input wire logic i_ref_clk,
  output logic o_prog_mode,
  output logic o_serial_path,
  output logic o_fuse_wr,
  output logic [1:0] o_fuse_wsel,
  output logic [7:0] o_fuse_wdata,
  output logic o_mem_lock_first,
  output logic [7:0] o_lock_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {o_prog_mode, o_serial_path, o_fuse_wr, o_fuse_wsel} = 5'h00;
    o_fuse_wdata = 8'h00;
    o_mem_lock_first = 1'b1;
    o_lock_byte = 8'hFF;
  end
  task enter(input logic ser);
    @(negedge i_ref_clk) {o_prog_mode, o_serial_path} = {1'b1, ser};
    repeat (2) @(negedge i_ref_clk);
  endtask : enter
  // released data bus shows inverse, never the stale value
  task write_fuse(input logic [1:0] sel, input logic [7:0] d);
    @(negedge i_ref_clk) {o_fuse_wr, o_fuse_wsel, o_fuse_wdata} = {1'b1, sel, d};
    @(negedge i_ref_clk) {o_fuse_wr, o_fuse_wdata} = {1'b0, ~d};
  endtask : write_fuse
  task leave;
    @(negedge i_ref_clk) {o_prog_mode, o_serial_path} = 2'h0;
  endtask : leave
  // only called once all fuses are written
  task lock_memory;
    @(negedge i_ref_clk) {o_mem_lock_first, o_lock_byte} = {1'b0, 8'hFE};
  endtask : lock_memory
endmodule : flcu_programmer_model

// ===== logic/flcu_fuse_lock_config_unit.sv
// fuse cells, fuse latching, boot lock decode, signature and calibration
module flcu_fuse_lock_config_unit #(
  parameter int unsigned DATA_W = 8,
  parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h3C, // arbitrary identity value
  parameter logic [7:0] CAL_3V = 8'h80,
  parameter logic [7:0] CAL_5V = 8'h80
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_prog_mode,
  input wire logic i_serial_path,
  input wire logic i_fuse_wr,
  input wire logic [1:0] i_fuse_wsel,
  input wire logic [DATA_W-1:0] i_fuse_wdata,
  input wire logic [1:0] i_fuse_rsel,
  input wire logic [DATA_W-1:0] i_lock_byte,
  input wire logic [1:0] i_sig_addr,
  input wire logic i_sig_cal_sel,
  input wire logic i_chip_erase,
  input wire logic i_cpu_reset,
  input wire logic i_boot_lock_hi,
  input wire logic i_boot_lock_lo,
  input wire logic i_mem_lock_first,
  input wire logic i_store_to_boot,
  input wire logic i_load_of_boot,
  input wire logic i_exec_in_boot,
  input wire logic i_vectors_in_app,
  output logic o_store_blocked,
  output logic o_load_blocked,
  output logic o_int_disable,
  output logic [DATA_W-1:0] o_fuse_rdata,
  output logic [DATA_W-1:0] o_sig_rdata,
  output logic o_fuse_wr_rejected,
  output logic o_data_erase,
  output logic [DATA_W-1:0] o_osc_calibration_reg,
  output logic [2:0] o_brownout_level,
  output logic o_debug_enable,
  output logic o_test_port_enable,
  output logic o_serial_prog_enable,
  output logic o_watchdog_forced_on,
  output logic o_keep_data_on_erase,
  output logic [1:0] o_boot_size,
  output logic o_reset_vector_select,
  output logic o_clock_div_eight,
  output logic [1:0] o_startup_time,
  output logic [3:0] o_clock_source,
  output logic o_clock_keep_in_sleep,
  output logic o_clock_out_pin_en,
  output logic o_latched
);

  // the fuse layout is byte wide; any other width breaks field positions
  generate
    if (DATA_W != flcu_pkg::BYTE_W) begin : g_bad_width
      $error("flcu: DATA_W must be 8");
    end
  endgenerate

  // write-select decode, shared by the write path and the reject check
  function automatic logic wsel_valid(input logic [1:0] sel);
    wsel_valid = (sel == flcu_pkg::WSEL_LOW) || (sel == flcu_pkg::WSEL_HIGH) ||
                 (sel == flcu_pkg::WSEL_EXT);
  endfunction : wsel_valid

  // live nonvolatile cells
  logic [7:0] cell_ext_ff;
  logic [7:0] cell_high_ff;
  logic [7:0] cell_low_ff;
  logic [7:0] nxt_cell_ext;
  logic [7:0] nxt_cell_high;
  logic [7:0] nxt_cell_low;
  logic fuse_wr_rejected_ff;
  logic nxt_fuse_wr_rejected;
  logic wr_ok;

  // latched copies and sequencer
  flcu_pkg::flcu_state_t state_ff;
  flcu_pkg::flcu_state_t nxt_state;
  logic [7:0] lat_ext_ff;
  logic [7:0] lat_high_ff;
  logic [7:0] lat_low_ff;
  logic [7:0] nxt_lat_ext;
  logic [7:0] nxt_lat_high;
  logic [7:0] nxt_lat_low;
  logic latched_ff;
  logic nxt_latched;
  logic do_latch;

  // read side and reset-time effects
  logic [7:0] fuse_rdata_ff;
  logic [7:0] sig_rdata_ff;
  logic [7:0] osc_cal_ff;
  logic data_erase_ff;
  logic [7:0] nxt_fuse_rdata;
  logic [7:0] nxt_sig_rdata;
  logic [7:0] nxt_osc_cal;
  logic nxt_data_erase;

  // fuse cell writes; chip erase has no path into the cells at all
  always_comb begin
    nxt_cell_ext = cell_ext_ff;
    nxt_cell_high = cell_high_ff;
    nxt_cell_low = cell_low_ff;
    nxt_fuse_wr_rejected = 1'b0;
    // first memory lock bit programmed (0) freezes every fuse
    wr_ok = i_prog_mode && i_mem_lock_first && wsel_valid(i_fuse_wsel);
    if (i_fuse_wr) begin
      if (!wr_ok) begin
        nxt_fuse_wr_rejected = 1'b1;
      end else begin
        case (i_fuse_wsel)
          flcu_pkg::WSEL_LOW: begin
            nxt_cell_low = i_fuse_wdata;
          end
          flcu_pkg::WSEL_HIGH: begin
            nxt_cell_high = i_fuse_wdata;
            if (i_serial_path) begin
              // serial path keeps its own enable so it cannot lock itself out
              nxt_cell_high[flcu_pkg::HI_SERIAL_PROG_EN] =
                cell_high_ff[flcu_pkg::HI_SERIAL_PROG_EN];
            end
          end
          flcu_pkg::WSEL_EXT: begin
            // unused bits forced high so they never read as programmed
            nxt_cell_ext = i_fuse_wdata | flcu_pkg::EXT_UNUSED_MASK;
          end
          default: begin
            // code 3 never gets here: wr_ok has already refused it
            nxt_cell_low = cell_low_ff;
          end
        endcase
      end
    end
  end

  // cells start at factory values, modelling a fresh part at power-on
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cell_ext_ff <= flcu_pkg::EXT_RESET;
      cell_high_ff <= flcu_pkg::HIGH_RESET;
      cell_low_ff <= flcu_pkg::LOW_RESET;
      fuse_wr_rejected_ff <= 1'b0;
    end else begin
      cell_ext_ff <= nxt_cell_ext;
      cell_high_ff <= nxt_cell_high;
      cell_low_ff <= nxt_cell_low;
      fuse_wr_rejected_ff <= nxt_fuse_wr_rejected;
    end
  end

  // latch sequencer: power-up, programming entry and programming exit
  always_comb begin
    nxt_state = state_ff;
    do_latch = 1'b0;
    case (state_ff)
      flcu_pkg::ST_PWRUP: begin
        // latch either way; starting in programming mode counts as an entry
        if (i_prog_mode) begin
          nxt_state = flcu_pkg::ST_PROG;
          do_latch = 1'b1;
        end else begin
          nxt_state = flcu_pkg::ST_NORMAL;
          do_latch = 1'b1;
        end
      end
      flcu_pkg::ST_NORMAL: begin
        // writes are refused here, so the cells cannot drift from the copies
        if (i_prog_mode) begin
          nxt_state = flcu_pkg::ST_PROG;
          do_latch = 1'b1;
        end
      end
      flcu_pkg::ST_PROG: begin
        // changes made in programming mode reach the latched copies on the way out
        if (!i_prog_mode) begin
          nxt_state = flcu_pkg::ST_NORMAL;
          do_latch = 1'b1;
        end
      end
      default: begin
        nxt_state = flcu_pkg::ST_PWRUP;
      end
    endcase
    // copy the live cells only on a latch event, otherwise hold
    nxt_lat_ext = do_latch ? cell_ext_ff : lat_ext_ff;
    nxt_lat_high = do_latch ? cell_high_ff : lat_high_ff;
    nxt_lat_low = do_latch ? cell_low_ff : lat_low_ff;
    nxt_latched = latched_ff | do_latch;
  end

  // latched copies hold between latch events
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_ff <= flcu_pkg::ST_PWRUP;
      lat_ext_ff <= flcu_pkg::EXT_RESET;
      lat_high_ff <= flcu_pkg::HIGH_RESET;
      lat_low_ff <= flcu_pkg::LOW_RESET;
      latched_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lat_ext_ff <= nxt_lat_ext;
      lat_high_ff <= nxt_lat_high;
      lat_low_ff <= nxt_lat_low;
      latched_ff <= nxt_latched;
    end
  end

  // read ports, calibration load and data-erase request
  always_comb begin
    // raw cell bits: programmed reads 0, unprogrammed reads 1
    // the lock byte is only echoed; its decode sits outside this block
    case (i_fuse_rsel)
      flcu_pkg::RSEL_LOW: nxt_fuse_rdata = cell_low_ff;
      flcu_pkg::RSEL_LOCK: nxt_fuse_rdata = i_lock_byte;
      flcu_pkg::RSEL_EXT: nxt_fuse_rdata = cell_ext_ff | flcu_pkg::EXT_UNUSED_MASK;
      flcu_pkg::RSEL_HIGH: nxt_fuse_rdata = cell_high_ff;
      default: nxt_fuse_rdata = cell_low_ff;
    endcase
    // signature space ignores every lock bit
    nxt_sig_rdata = 8'hFF;
    if (i_sig_cal_sel) begin
      case (i_sig_addr)
        flcu_pkg::CAL_ADDR_3V: nxt_sig_rdata = CAL_3V;
        flcu_pkg::CAL_ADDR_5V: nxt_sig_rdata = CAL_5V;
        default: nxt_sig_rdata = 8'hFF;
      endcase
    end else begin
      case (i_sig_addr)
        flcu_pkg::SIG_ADDR_0: nxt_sig_rdata = SIG_BYTE0;
        flcu_pkg::SIG_ADDR_1: nxt_sig_rdata = SIG_BYTE1;
        flcu_pkg::SIG_ADDR_2: nxt_sig_rdata = SIG_BYTE2;
        default: nxt_sig_rdata = 8'hFF;
      endcase
    end
    // software may retune after reset; every reset restores the 3V value
    nxt_osc_cal = i_cpu_reset ? CAL_3V : osc_cal_ff;
    // live cell used: keep-data acts without waiting for a latch
    nxt_data_erase = i_chip_erase && cell_high_ff[flcu_pkg::HI_KEEP_DATA];
  end

  // read and reset-effect registers
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      fuse_rdata_ff <= 8'hFF;
      sig_rdata_ff <= 8'hFF;
      osc_cal_ff <= CAL_3V;
      data_erase_ff <= 1'b0;
    end else begin
      fuse_rdata_ff <= nxt_fuse_rdata;
      sig_rdata_ff <= nxt_sig_rdata;
      osc_cal_ff <= nxt_osc_cal;
      data_erase_ff <= nxt_data_erase;
    end
  end

  // boot section protection decode from the two boot lock bits
  always_comb begin
    o_store_blocked = 1'b0;
    o_load_blocked = 1'b0;
    // lock bits are active low: 0 means programmed
    case ({i_boot_lock_hi, i_boot_lock_lo})
      2'h3: begin
        o_store_blocked = 1'b0;
        o_load_blocked = 1'b0;
      end
      2'h2: begin
        o_store_blocked = i_store_to_boot;
      end
      2'h0: begin
        o_store_blocked = i_store_to_boot;
        o_load_blocked = i_load_of_boot && !i_exec_in_boot;
      end
      2'h1: begin
        o_load_blocked = i_load_of_boot && !i_exec_in_boot;
      end
      default: begin
        o_store_blocked = 1'b0;
      end
    endcase
    // read-protect modes have the upper lock bit programmed
    o_int_disable = !i_boot_lock_hi && i_vectors_in_app && i_exec_in_boot;
  end

  // configuration outputs come from the latched copies, except o_keep_data_on_erase from the live cell
  assign o_brownout_level = lat_ext_ff[flcu_pkg::EXT_BROWNOUT_LSB +: 3];

  // high byte: a programmed fuse reads 0, so every enable inverts
  assign o_debug_enable = !lat_high_ff[flcu_pkg::HI_DEBUG_EN];
  assign o_test_port_enable = !lat_high_ff[flcu_pkg::HI_TEST_PORT_EN];
  assign o_serial_prog_enable = !lat_high_ff[flcu_pkg::HI_SERIAL_PROG_EN];
  assign o_watchdog_forced_on = !lat_high_ff[flcu_pkg::HI_WATCHDOG_ON];
  assign o_keep_data_on_erase = !cell_high_ff[flcu_pkg::HI_KEEP_DATA];
  assign o_boot_size = lat_high_ff[flcu_pkg::HI_BOOT_SIZE_LSB +: 2];
  assign o_reset_vector_select = !lat_high_ff[flcu_pkg::HI_RESET_VECTOR];

  // low byte: divider flag, then start-up and clock source as raw fields
  assign o_clock_div_eight = !lat_low_ff[flcu_pkg::LO_CLOCK_DIV8];
  assign o_startup_time = lat_low_ff[flcu_pkg::LO_STARTUP_LSB +: 2];
  assign o_clock_source = lat_low_ff[flcu_pkg::LO_CLOCK_SRC_LSB +: 4];

  // debug costs sleep current: clock parts stay alive while it is on
  assign o_clock_keep_in_sleep = !lat_high_ff[flcu_pkg::HI_DEBUG_EN];
  assign o_clock_out_pin_en = !lat_low_ff[flcu_pkg::LO_CLOCK_OUT];

  // registered status, read data and reset effects out to the ports
  assign o_latched = latched_ff;
  assign o_fuse_rdata = fuse_rdata_ff;
  assign o_sig_rdata = sig_rdata_ff;
  assign o_fuse_wr_rejected = fuse_wr_rejected_ff;
  assign o_data_erase = data_erase_ff;
  assign o_osc_calibration_reg = osc_cal_ff;

endmodule : flcu_fuse_lock_config_unit

// ===== shared/flcu_pkg.sv
// constants for the fuse and lock configuration unit
package flcu_pkg;
  // byte width of every fuse, signature and calibration byte
  localparam int unsigned BYTE_W = 8;
  // fuse byte select codes on the write side (programming)
  localparam logic [1:0] WSEL_LOW = 2'h0;
  localparam logic [1:0] WSEL_HIGH = 2'h1;
  localparam logic [1:0] WSEL_EXT = 2'h2;
  // fuse byte select codes on the read side
  localparam logic [1:0] RSEL_LOW = 2'h0;
  localparam logic [1:0] RSEL_LOCK = 2'h1;
  localparam logic [1:0] RSEL_EXT = 2'h2;
  localparam logic [1:0] RSEL_HIGH = 2'h3;
  // factory values of the three fuse bytes (0 = programmed)
  localparam logic [7:0] EXT_RESET = 8'hFD;
  localparam logic [7:0] HIGH_RESET = 8'h99;
  localparam logic [7:0] LOW_RESET = 8'h62;
  // extended byte: unused upper bits always read as one
  localparam logic [7:0] EXT_UNUSED_MASK = 8'hF8;
  localparam int unsigned EXT_BROWNOUT_LSB = 0;
  localparam int unsigned EXT_BROWNOUT_W = 3;
  // high byte field positions
  localparam int unsigned HI_DEBUG_EN = 7;
  localparam int unsigned HI_TEST_PORT_EN = 6;
  localparam int unsigned HI_SERIAL_PROG_EN = 5;
  localparam int unsigned HI_WATCHDOG_ON = 4;
  localparam int unsigned HI_KEEP_DATA = 3;
  localparam int unsigned HI_BOOT_SIZE_LSB = 1;
  localparam int unsigned HI_BOOT_SIZE_W = 2;
  localparam int unsigned HI_RESET_VECTOR = 0;
  // low byte field positions
  localparam int unsigned LO_CLOCK_DIV8 = 7;
  localparam int unsigned LO_CLOCK_OUT = 6;
  localparam int unsigned LO_STARTUP_LSB = 4;
  localparam int unsigned LO_STARTUP_W = 2;
  localparam int unsigned LO_CLOCK_SRC_LSB = 0;
  localparam int unsigned LO_CLOCK_SRC_W = 4;
  // signature address space
  localparam logic [1:0] SIG_ADDR_0 = 2'h0;
  localparam logic [1:0] SIG_ADDR_1 = 2'h1;
  localparam logic [1:0] SIG_ADDR_2 = 2'h2;
  localparam logic [1:0] CAL_ADDR_3V = 2'h1;
  localparam logic [1:0] CAL_ADDR_5V = 2'h3;
  // latch sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_PWRUP = 3'h1,
    ST_NORMAL = 3'h2,
    ST_PROG = 3'h4
  } flcu_state_t;
endpackage : flcu_pkg
